// File: rtl/cmc_core.sv
// CAN control, timing and diagnostic core with classic Wishbone slave.
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Function
// - Standard-ID buffers also compare low 18 data-field bits through mask.
// - Mask bit one makes the bit don't-care; one mask serves both formats.
// - Read-only info register: last error code and last receive buffer.
// - Read-only register shows transmit and receive error counters.
// - Read-only register reports the frame currently on the bus.
// - Prescaler register accessible only while init flag is one.
// - Diagnostic capture readable only in diagnostic mode with init off.
// - Capture counts every bus bit except one sampled in the SOF cycle, accumulating across frames; SOF does not clear the count.
// - Last 8 bits freeze on error or ack delimiter; reset at SOF.
// - Bit-timing register always readable, writable only in init mode.
// - Sleep mode stands by and wakes on bus activity.
// - Stop mode stands by, ignores bus; only CPU access leaves it.
// - Protocol clock is base clock over twice one plus prescaler.
// - Bit-time in bits 4..0, sample point in 9..5; segments value plus one.
module cmc_core (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Protocol engine status
    input  wire logic [3:0]  last_err_i,
    input  wire logic [4:0]  last_buf_i,
    input  wire logic [7:0]  tx_err_cnt_i,
    input  wire logic [7:0]  rx_err_cnt_i,
    input  wire logic [15:0] frame_info_i,
    input  wire logic        bus_err_i,
    input  wire logic        ack_delim_i,
    input  wire logic        sof_i,
    // Acceptance check
    input  wire logic [1:0]  acc_sel_i,
    input  wire logic [31:0] acc_rx_i,
    input  wire logic [31:0] acc_ref_i,
    output logic             acc_hit_o,
    // CAN pin and mode outputs
    input  wire logic        can_rx_i,
    output logic             init_o,
    output logic             standby_o,
    output logic             bit_sample_o
);
    import cmc_pkg::*;
    typedef struct packed {
        logic [NUM_MASK-1:0][31:0] mask;
        logic [15:0] ctrl;
        logic [15:0] def;
        logic [15:0] ie;
        logic [BRP_W-1:0] brp;
        logic [15:0] sync;
        logic [7:0]  cap;
        logic [7:0]  cnt;
        logic        frozen;
        logic        rx_prev;
        logic [31:0] dat;
        logic        ack;
        logic        hit;
        logic        sync1;
        logic        sync2;
        logic        stby;
    } cmc_core_type;
    cmc_core_type st_r;
    cmc_core_type st_nxt;
    logic         tick;
    logic         smp;
    logic         smp_bit;
    logic         req;
    logic         wr;
    logic [15:0]  wd;
    logic [31:0]  rd;
    logic [31:0]  mrec;
    logic         init;
    logic         diag_ok;

    // Set/clear format: low byte clears, high byte sets
    function automatic logic [15:0] setclr(input logic [15:0] cur,
                                           input logic [15:0] w);
        setclr = (cur & ~{8'h00, w[7:0]}) | {8'h00, w[15:8]};
    endfunction

    // Mask pair decode
    function automatic logic [2:0] mask_slot(input logic [5:0] a);
        mask_slot = {a < OFS_CTRL - 6'h04, a[4:3]};
    endfunction

    cmc_prescaler u_psc (
        .mclk_i            (mclk_i),
        .nrst_i            (nrst_i),
        .run_i             (~init & ~st_r.ctrl[CTRL_SLEEP]
                            & ~st_r.ctrl[CTRL_STOP]),
        .prescaler_field_i (st_r.brp),
        .tick_o            (tick)
    );

    cmc_bit_timer u_bt (
        .mclk_i               (mclk_i),
        .nrst_i               (nrst_i),
        .tick_i               (tick),
        .bit_time_field_i     (st_r.sync[DBT_LSB +: FIELD5_W]),
        .sample_point_field_i (st_r.sync[SPT_LSB +: FIELD5_W]),
        .rx_i                 (st_r.sync2),
        .sample_o             (smp),
        .bit_o                (smp_bit)
    );

    always_comb begin
        init    = st_r.ctrl[CTRL_INIT];
        diag_ok = st_r.def[DEF_DIAG] & ~init;
        req     = wb_cyc_i & wb_stb_i & ~st_r.ack;
        wr      = req & wb_we_i;
        wd      = wb_dat_i[15:0];
        mrec    = st_r.mask[acc_sel_i];
        rd      = 32'h0000_0000;
        st_nxt  = st_r;
        st_nxt.ack   = req;
        st_nxt.sync1 = can_rx_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.rx_prev = st_r.sync2;
        // Masked compare over full 32 bits covers data bits too
        st_nxt.hit = &(~(acc_rx_i ^ acc_ref_i) | mrec);
        // Wake on bus activity in sleep, not in stop
        if (st_r.ctrl[CTRL_SLEEP] && !st_r.ctrl[CTRL_STOP]
            && st_r.sync2 != st_r.rx_prev) begin
            st_nxt.ctrl[CTRL_SLEEP] = 1'b0;
        end
        // Diagnostic capture
        if (sof_i) begin
            st_nxt.cap    = '0;
            st_nxt.frozen = 1'b0;
        end else if (bus_err_i || ack_delim_i) begin
            st_nxt.frozen = 1'b1;
        end
        if (smp && !sof_i) begin
            st_nxt.cnt = st_r.cnt + 8'h01;
            if (!st_r.frozen && !(bus_err_i || ack_delim_i)) begin
                st_nxt.cap = {st_r.cap[DIAG_BITS-2:0], smp_bit};
            end
        end
        // Register reads
        // Mask halves sit on word offsets only
        if (wb_adr_i < OFS_SYNC && wb_adr_i[1:0] == '0) begin
            rd[15:0] = wb_adr_i[2] ?
                st_r.mask[mask_slot(wb_adr_i)[1:0]][31:16] :
                st_r.mask[mask_slot(wb_adr_i)[1:0]][15:0];
        end else begin
            unique case (wb_adr_i)
                OFS_SYNC: rd[15:0] = st_r.sync;
                OFS_CTRL: rd[15:0] = st_r.ctrl;
                OFS_DEF:  rd[15:0] = st_r.def;
                OFS_LAST: rd[15:0] = {7'h00, last_buf_i, last_err_i};
                OFS_ERC:  rd[15:0] = {rx_err_cnt_i, tx_err_cnt_i};
                OFS_IE:   rd[15:0] = st_r.ie;
                OFS_BA:   rd[15:0] = frame_info_i;
                OFS_BRP: begin
                    if (init) begin
                        rd[BRP_W-1:0] = st_r.brp;
                    end
                end
                OFS_DIAG: begin
                    if (diag_ok) begin
                        rd[15:0] = {st_r.cnt, st_r.cap};
                    end
                end
                default: rd = 32'h0000_0000;
            endcase
        end
        if (req && !wb_we_i) begin
            st_nxt.dat = rd;
        end
        // Register writes, low halfword lanes
        if (wr && (&wb_sel_i[1:0])) begin
            if (wb_adr_i < OFS_SYNC && wb_adr_i[1:0] == '0) begin
                if (wb_adr_i[2]) begin
                    st_nxt.mask[mask_slot(wb_adr_i)[1:0]][31:16] = wd;
                end else begin
                    st_nxt.mask[mask_slot(wb_adr_i)[1:0]][15:0] = wd;
                end
            end else begin
                unique case (wb_adr_i)
                    OFS_SYNC: begin
                        if (init) begin
                            st_nxt.sync = wd & SYNC_WMASK;
                        end
                    end
                    OFS_CTRL: begin
                        // A control write whose low byte clears the stop bit and whose high byte does not set it takes the core out of stop
                        st_nxt.ctrl = setclr(st_r.ctrl, wd);
                    end
                    OFS_DEF: st_nxt.def = setclr(st_r.def, wd);
                    OFS_IE:  st_nxt.ie  = setclr(st_r.ie, wd);
                    OFS_BRP: begin
                        if (init) begin
                            st_nxt.brp = wd[BRP_W-1:0];
                        end
                    end
                    default: st_nxt.dat = st_nxt.dat;
                endcase
            end
        end
        // Standby flag registered so the output comes from a flop
        st_nxt.stby = st_nxt.ctrl[CTRL_SLEEP] | st_nxt.ctrl[CTRL_STOP];
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r       <= '0;
            st_r.ctrl  <= CTRL_RST;
            st_r.sync  <= SYNC_RST;
            st_r.sync1 <= 1'b1;
            st_r.sync2 <= 1'b1;
            st_r.rx_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs from the state register; sample strobe from the bit timer
    assign wb_dat_o     = st_r.dat;
    assign wb_ack_o     = st_r.ack;
    assign acc_hit_o    = st_r.hit;
    assign init_o       = st_r.ctrl[CTRL_INIT];
    assign standby_o    = st_r.stby;
    assign bit_sample_o = smp;
endmodule // cmc_core

// File: rtl/cmc_pkg.sv
// Package with register map, field layout and timing constants for cmc.
package cmc_pkg;
    localparam int          ADDR_W        = 6;
    localparam logic [5:0]  OFS_MASK_LO0  = 6'h00; // +8 per mask pair
    localparam logic [5:0]  OFS_MASK_HI0  = 6'h04;
    localparam logic [5:0]  OFS_MASK_STEP = 6'h08;
    localparam logic [5:0]  OFS_CTRL      = 6'h20;
    localparam logic [5:0]  OFS_DEF       = 6'h24;
    localparam logic [5:0]  OFS_LAST      = 6'h28;
    localparam logic [5:0]  OFS_ERC       = 6'h2c;
    localparam logic [5:0]  OFS_IE        = 6'h30;
    localparam logic [5:0]  OFS_BA        = 6'h34;
    localparam logic [5:0]  OFS_BRP       = 6'h38;
    localparam logic [5:0]  OFS_DIAG      = 6'h3c;
    localparam logic [5:0]  OFS_SYNC      = 6'h1c;
    localparam int          NUM_MASK      = 4;
    // Control bits
    localparam int          CTRL_INIT     = 0;
    localparam int          CTRL_SLEEP    = 1;
    localparam int          CTRL_STOP     = 2;
    localparam int          DEF_DIAG      = 0;
    // Timing field layout
    localparam int          DBT_LSB       = 0;
    localparam int          SPT_LSB       = 5;
    localparam int          SJW_LSB       = 10;
    localparam int          FIELD5_W      = 5;
    localparam int          BRP_W         = 6;
    localparam logic [15:0] SYNC_WMASK    = 16'h1fff;
    localparam logic [15:0] CTRL_RST      = 16'h0001;
    localparam logic [15:0] SYNC_RST      = 16'h0000;
    localparam logic [7:0]  ERR_LIMIT     = 8'hff;
    localparam int          DIAG_BITS     = 8;
endpackage

// File: rtl/cmc_prescaler.sv
// Protocol-layer clock tick generator.
`timescale 1ns/1ps
module cmc_prescaler (
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      nrst_i,
    // Control
    input  wire logic                      run_i,
    input  wire logic [cmc_pkg::BRP_W-1:0] prescaler_field_i,
    // Tick
    output logic                           tick_o
);
    import cmc_pkg::*;
    typedef struct packed {
        logic [BRP_W:0] cnt;
        logic           tick;
    } cmc_psc_type;
    cmc_psc_type st_r;
    cmc_psc_type st_nxt;
    logic [BRP_W:0] lim;

    always_comb begin
        // Divide by twice one plus the prescaler field
        lim = {prescaler_field_i, 1'b1};
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run_i) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= lim) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign tick_o = st_r.tick;
endmodule // cmc_prescaler

// File: rtl/cmc_bit_timer.sv
// Bit timer: samples the bus at the sample point of each bit time.
`timescale 1ns/1ps
module cmc_bit_timer (
    // Clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         nrst_i,
    // Timing
    input  wire logic                         tick_i,
    input  wire logic [cmc_pkg::FIELD5_W-1:0] bit_time_field_i,
    input  wire logic [cmc_pkg::FIELD5_W-1:0] sample_point_field_i,
    input  wire logic                         rx_i,
    // Sample
    output logic                              sample_o,
    output logic                              bit_o
);
    import cmc_pkg::*;
    typedef struct packed {
        logic [FIELD5_W-1:0] cnt;
        logic                smp;
        logic                bitv;
    } cmc_bt_type;
    cmc_bt_type st_r;
    cmc_bt_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.smp = 1'b0;
        if (tick_i) begin
            // Segments last field value plus one periods
            if (st_r.cnt == bit_time_field_i) begin
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
            if (st_r.cnt == sample_point_field_i) begin
                st_nxt.smp = 1'b1;
                st_nxt.bitv = rx_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{cnt: '0, smp: 1'b0, bitv: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sample_o = st_r.smp;
    assign bit_o    = st_r.bitv;
endmodule // cmc_bit_timer

// File: test/cmc_core_sva.sv
// Checker of bus answers, register gating, standby and sampling.
`timescale 1ns/1ps
module cmc_core_sva
    import cmc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Acceptance, pin and modes
    input  wire logic [31:0] acc_rx_i,
    input  wire logic [31:0] acc_ref_i,
    input  wire logic        acc_hit_o,
    input  wire logic        can_rx_i,
    input  wire logic        init_o,
    input  wire logic        standby_o,
    input  wire logic        bit_sample_o
);
    logic       rx_q_r;
    logic [3:0] quiet_r;
    logic       req;
    logic       rd;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd  = req && !wb_we_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Cycles since the last line change or register access
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_q_r  <= 1'b1;
            quiet_r <= 4'hf;
        end else begin
            rx_q_r <= can_rx_i;
            if (wb_ack_o || rx_q_r != can_rx_i)
                quiet_r <= 4'h0;
            else if (quiet_r != 4'hf)
                quiet_r <= quiet_r + 4'h1;
        end
    end
    a_ack_answer: assert property (req |=> wb_ack_o)
        else $error("no acknowledge after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_unmapped_zero: assert property
        (rd && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_brp_hidden: assert property
        (rd && wb_adr_i == OFS_BRP && !init_o |=> wb_dat_o == 32'h0)
        else $error("prescaler visible outside init");
    a_diag_hidden: assert property
        (rd && wb_adr_i == OFS_DIAG && init_o |=> wb_dat_o == 32'h0)
        else $error("capture visible in init");
    a_wake_cause: assert property ($fell(standby_o) |-> quiet_r < 4'ha)
        else $error("standby left without cause");
    a_halt_idle: assert property
        ((init_o || standby_o) [*4] |-> !bit_sample_o)
        else $error("sample while protocol clock halted");
    a_sample_gap: assert property (bit_sample_o |=> !bit_sample_o [*8])
        else $error("sample points too close");
    a_accept_equal: assert property
        ($past(nrst_i) && $past(acc_rx_i == acc_ref_i) |-> acc_hit_o)
        else $error("equal pattern not accepted");
endmodule // cmc_core_sva

// File: test/cmc_bus_model.sv
// Bus model: recessive idle line, toggling traffic on demand.
`timescale 1ns/1ps
module cmc_bus_model (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    // Traffic control and line
    input  wire logic act_i,
    output logic      rx_o
);
    logic [1:0] div_r;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_r <= 2'h0;
            rx_o  <= 1'b1;
        end else if (!act_i) begin
            div_r <= 2'h0;
            rx_o  <= 1'b1;
        end else begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h2)
                rx_o <= !rx_o;
        end
    end
endmodule // cmc_bus_model

// File: test/cmc_core_test.sv
// Self-checking bench of the cmc core.
`timescale 1ns/1ps
module cmc_core_test;
    import cmc_pkg::*;
    logic        mclk_i, nrst_i = 1'b0, act = 1'b0, can_rx_i;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        bus_err_i = 1'b0, ack_delim_i = 1'b0, sof_i = 1'b0;
    logic        wb_ack_o, acc_hit_o, init_o, standby_o, bit_sample_o;
    logic [5:0]  wb_adr_i = 6'h0;
    logic [3:0]  wb_sel_i = 4'hf, last_err_i = 4'h0;
    logic [4:0]  last_buf_i = 5'h0;
    logic [7:0]  tx_err_cnt_i = 8'h0, rx_err_cnt_i = 8'h0;
    logic [15:0] frame_info_i = 16'h0, v;
    logic [1:0]  acc_sel_i = 2'h0;
    logic [31:0] wb_dat_i = 32'h0, acc_rx_i = 32'h0, acc_ref_i = 32'h0;
    logic [31:0] wb_dat_o, q, r, m, x, seed = 32'h19d54638;
    int          num_errors = 0, n_compared = 0, samp_n = 0, p, b, s, d;
    cmc_core u_cmc_core (.mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .last_err_i,
        .last_buf_i, .tx_err_cnt_i, .rx_err_cnt_i, .frame_info_i, .bus_err_i,
        .ack_delim_i, .sof_i, .acc_sel_i, .acc_rx_i, .acc_ref_i, .acc_hit_o,
        .can_rx_i, .init_o, .standby_o, .bit_sample_o);
    cmc_bus_model u_cmc_bus_model (.mclk_i, .nrst_i, .act_i(act),
        .rx_o(can_rx_i));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic exp_hit(logic [31:0] mk, a, c);
        return ((a ^ c) & ~mk) == 32'h0;
    endfunction
    function automatic int exp_per(int pre, int bt);
        return 2 * (pre + 1) * (bt + 1);
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(logic w, logic [5:0] a, logic [15:0] dt);
        int n;
        n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, dt};
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 40) chk("ack", 32'h1, 32'h0);
    endtask
    task automatic per(output int c);
        int n;
        n = 0;
        while (bit_sample_o !== 1'b1 && n < 500) begin
            @(posedge mclk_i);
            n++;
        end
        c = 0;
        do begin
            @(posedge mclk_i);
            c++;
        end while (bit_sample_o !== 1'b1 && c < 500);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (bit_sample_o === 1'b1) samp_n <= samp_n + 1;
    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        $display("[FAIL] watchdog expected end seen hang");
        final_report();
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        nrst_i <= 1'b1;
        wb(0, OFS_CTRL, 0);
        chk("ctrl", {16'h0, CTRL_RST}, q);
        chk("init", 32'h1, {31'h0, init_o});
        wb(0, 6'h02, 0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            last_err_i <= r[3:0];
            last_buf_i <= r[8:4];
            tx_err_cnt_i <= r[23:16];
            rx_err_cnt_i <= r[31:24];
            frame_info_i <= r[15:0];
            wb(1, OFS_ERC, ~r[15:0]);
            wb(0, OFS_LAST, 0);
            chk("last", {23'h0, r[8:4], r[3:0]}, q);
            wb(0, OFS_ERC, 0);
            chk("erc", {16'h0, r[31:16]}, q);
            wb(0, OFS_BA, 0);
            chk("ba", {16'h0, r[15:0]}, q);
        end
        m = {16'h0, SYNC_RST};
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            b = (i == 0) ? 0 : int'(r[0]);
            s = (i == 0) ? 4 : 4 + int'(r[7:4]) % 13;
            d = (i == 0) ? 7 : s + 3 + int'(r[9:8]);
            v = 16'(d | (s << 5) | (int'(r[11:10]) << 10));
            wb(1, OFS_BRP, 16'(b));
            wb_sel_i <= 4'hc;
            wb(1, OFS_SYNC, v);
            wb_sel_i <= 4'hf;
            wb(0, OFS_SYNC, 0);
            chk("sync sel", {16'h0, m[15:0]}, q);
            wb(1, OFS_SYNC, v);
            wb(0, OFS_BRP, 0);
            chk("brp", b, q);
            wb(1, OFS_CTRL, 16'h0001);
            wb(1, OFS_SYNC, ~v);
            wb(1, OFS_BRP, 16'h003f);
            wb(0, OFS_SYNC, 0);
            chk("sync locked", {16'h0, v}, q);
            m = {16'h0, v};
            wb(0, OFS_BRP, 0);
            chk("brp hidden", 32'h0, q);
            per(p);
            chk("period", exp_per(b, d), p);
            wb(1, OFS_CTRL, 16'h0100);
            wb(0, OFS_BRP, 0);
            chk("brp kept", b, q);
        end
        for (int a = 0; a < 3; a++) begin
            m = (a == 0) ? 32'h0003ffff : rnd();
            wb(1, OFS_MASK_LO0 + OFS_MASK_STEP * 6'(a), m[15:0]);
            wb(1, OFS_MASK_HI0 + OFS_MASK_STEP * 6'(a), m[31:16]);
            for (int j = 0; j < 6; j++) begin
                r = rnd();
                x = (j == 0) ? r : r ^ (rnd() & (j[0] ? m : 32'hffffffff));
                acc_sel_i <= 2'(a);
                acc_ref_i <= r;
                acc_rx_i <= x;
                repeat (2) @(posedge mclk_i);
                chk("hit", {31'h0, exp_hit(m, x, r)}, {31'h0, acc_hit_o});
            end
        end
        wb(0, OFS_MASK_LO0 + 6'h02, 0);
        chk("unmapped mask", 32'h0, q);
        wb(1, OFS_CTRL, 16'h0001);
        wb(0, OFS_DIAG, 0);
        chk("diag normal", 32'h0, q);
        wb(1, OFS_DEF, 16'h0100);
        act <= 1'b1;
        sof_i <= 1'b1;
        @(posedge mclk_i);
        sof_i <= 1'b0;
        repeat (300) @(posedge mclk_i);
        ack_delim_i <= 1'b1;
        @(posedge mclk_i);
        ack_delim_i <= 1'b0;
        wb(1, OFS_CTRL, 16'h0400);
        repeat (40) @(posedge mclk_i);
        chk("stop holds", 32'h1, {31'h0, standby_o});
        wb(0, OFS_DIAG, 0);
        r = q;
        b = samp_n;
        wb(1, OFS_CTRL, 16'h0006);
        repeat (300) @(posedge mclk_i);
        wb(1, OFS_CTRL, 16'h0400);
        repeat (10) @(posedge mclk_i);
        wb(0, OFS_DIAG, 0);
        chk("diag", {16'h0, 8'(r[15:8] + 8'(samp_n - b)), r[7:0]}, q);
        act <= 1'b0;
        wb(1, OFS_CTRL, 16'h0006);
        repeat (5) @(posedge mclk_i);
        chk("stop left", 32'h0, {31'h0, standby_o});
        wb(1, OFS_CTRL, 16'h0200);
        repeat (10) @(posedge mclk_i);
        chk("sleep", 32'h1, {31'h0, standby_o});
        act <= 1'b1;
        repeat (20) @(posedge mclk_i);
        chk("wake", 32'h0, {31'h0, standby_o});
        final_report();
    end
endmodule // cmc_core_test
bind cmc_core cmc_core_sva u_cmc_core_sva (.mclk_i, .nrst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .acc_rx_i,
    .acc_ref_i, .acc_hit_o, .can_rx_i, .init_o, .standby_o, .bit_sample_o);
